// File: common/ihs_pkg.sv
package ihs_pkg;
  // -----------------------------------------------------------------
  // register byte addresses
  // -----------------------------------------------------------------
  localparam int ADDR_W = 7;
  localparam logic [ADDR_W-1:0] ADDR_HS_HIGH = 7'h24;
  localparam logic [ADDR_W-1:0] ADDR_HS_LOW = 7'h28;
  localparam logic [ADDR_W-1:0] ADDR_MASKED_STATUS = 7'h2c;
  localparam logic [ADDR_W-1:0] ADDR_EVENT_MASK = 7'h30;
  localparam logic [ADDR_W-1:0] ADDR_RAW_STATUS = 7'h34;
  localparam logic [ADDR_W-1:0] ADDR_RX_THRESHOLD = 7'h38;
  localparam logic [ADDR_W-1:0] ADDR_TX_THRESHOLD = 7'h3c;
  localparam logic [ADDR_W-1:0] ADDR_COMBINED_CLEAR = 7'h40;

  // -----------------------------------------------------------------
  // event field positions
  // -----------------------------------------------------------------
  localparam int EV_COUNT = 12;
  localparam int EV_GENERAL_CALL = 11;
  localparam int EV_START_SEEN = 10;
  localparam int EV_STOP_SEEN = 9;
  localparam int EV_ACTIVITY = 8;
  localparam int EV_SLAVE_TX_DONE = 7;
  localparam int EV_TX_ABORT = 6;
  localparam int EV_READ_REQUEST = 5;
  localparam int EV_TX_EMPTY = 4;
  localparam int EV_TX_OVERFLOW = 3;
  localparam int EV_RX_FULL = 2;
  localparam int EV_RX_OVERFLOW = 1;
  localparam int EV_RX_UNDERFLOW = 0;

  // -----------------------------------------------------------------
  // widths and reset values
  // -----------------------------------------------------------------
  localparam int HS_COUNT_W = 16;
  localparam int THRESHOLD_W = 8;
  localparam logic [EV_COUNT-1:0] EVENT_MASK_RESET = 12'h8ff;
  localparam logic [EV_COUNT-1:0] EVENT_RESET = 12'h000;
  // level-driven events are recomputed, all others are sticky
  localparam logic [EV_COUNT-1:0] STICKY_EVENTS = 12'hfeb;
  localparam logic [HS_COUNT_W-1:0] HS_COUNT_RESET = 16'h0000;
  localparam logic [THRESHOLD_W-1:0] THRESHOLD_RESET = 8'h00;

  // -----------------------------------------------------------------
  // bus responses
  // -----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage : ihs_pkg

// File: common/ihs_cond_if.sv
`timescale 1ns/1ps
`default_nettype none
interface ihs_cond_if;
  logic scl_pin;
  logic sda_pin;
  logic start_pulse;
  logic stop_pulse;
  modport detector (input scl_pin, input sda_pin, output start_pulse, output stop_pulse);
  modport user (output scl_pin, output sda_pin, input start_pulse, input stop_pulse);
endinterface : ihs_cond_if
`default_nettype wire

// File: rtl/ihs_bus_cond.sv
`timescale 1ns/1ps
`default_nettype none
module ihs_bus_cond
  import ihs_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  ihs_cond_if.detector cond
);
  // -----------------------------------------------------------------
  // pin synchronisers
  // -----------------------------------------------------------------
  logic scl_meta_ff, scl_sync_ff, scl_prev_ff;
  logic sda_meta_ff, sda_sync_ff, sda_prev_ff;

  // pins idle high, so reset to high avoids a false condition at release
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      scl_meta_ff <= 1'b1;
      scl_sync_ff <= 1'b1;
      sda_meta_ff <= 1'b1;
      sda_sync_ff <= 1'b1;
    end else begin
      scl_meta_ff <= cond.scl_pin;
      scl_sync_ff <= scl_meta_ff;
      sda_meta_ff <= cond.sda_pin;
      sda_sync_ff <= sda_meta_ff;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      scl_prev_ff <= 1'b1;
      sda_prev_ff <= 1'b1;
    end else begin
      scl_prev_ff <= scl_sync_ff;
      sda_prev_ff <= sda_sync_ff;
    end
  end

  // -----------------------------------------------------------------
  // conditions: sda moves while scl stays high
  // -----------------------------------------------------------------
  always_comb begin
    cond.start_pulse = scl_prev_ff && scl_sync_ff && sda_prev_ff && !sda_sync_ff;
    cond.stop_pulse = scl_prev_ff && scl_sync_ff && !sda_prev_ff && sda_sync_ff;
  end
endmodule : ihs_bus_cond
`default_nettype wire

// File: rtl/ihs_event_regs.sv
// Function
// - software loads high-speed scl high count
// - software loads high-speed scl low count
// - general call flag only on acked call
// - start or repeated start sets flag
// - stop condition sets flag
// - activity flag sticks until software clears
// - slave transmitter sees master nack
// - transmitter cannot finish queued fifo actions
// - external master reads us as slave
// - tx level at or below threshold
// - command written while tx fifo full
// - rx level at or above threshold
// - byte arrives while rx fifo full
// - data port read while rx empty
// - mask register resets to 0x8ff
// - raw and masked read-only event views
// - receive threshold level register
// - transmit threshold level register
// - combined clear read clears sticky flags
`timescale 1ns/1ps
`default_nettype none
module ihs_event_regs
  import ihs_pkg::*;
#(
  parameter int LEVEL_W = 8,
  parameter int TX_FIFO_DEPTH = 8,
  parameter int RX_FIFO_DEPTH = 8
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic general_call_ack_pulse,
  input wire logic activity_pulse,
  input wire logic slave_tx_nack_pulse,
  input wire logic tx_abort_pulse,
  input wire logic read_request_pulse,
  input wire logic data_cmd_write_pulse,
  input wire logic data_cmd_read_pulse,
  input wire logic rx_byte_pulse,
  input wire logic [LEVEL_W-1:0] tx_fifo_level,
  input wire logic [LEVEL_W-1:0] rx_fifo_level,
  output logic [HS_COUNT_W-1:0] hs_scl_high_count,
  output logic [HS_COUNT_W-1:0] hs_scl_low_count,
  output logic [THRESHOLD_W-1:0] receive_threshold_level,
  output logic [THRESHOLD_W-1:0] transmit_threshold_level,
  output logic intr
);
  localparam logic [LEVEL_W-1:0] TX_FULL_LEVEL = LEVEL_W'(TX_FIFO_DEPTH);
  localparam logic [LEVEL_W-1:0] RX_FULL_LEVEL = LEVEL_W'(RX_FIFO_DEPTH);

  // -----------------------------------------------------------------
  // bus condition detector
  // -----------------------------------------------------------------
  ihs_cond_if cond ();

  assign cond.scl_pin = scl_in;
  assign cond.sda_pin = sda_in;

  ihs_bus_cond u_bus_cond (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .cond(cond)
  );

  // -----------------------------------------------------------------
  // registers
  // -----------------------------------------------------------------
  logic [HS_COUNT_W-1:0] hs_high_ff, hs_low_ff;
  logic [THRESHOLD_W-1:0] receive_threshold_level_ff, transmit_threshold_level_ff;
  logic [EV_COUNT-1:0] mask_ff, raw_ff, nxt_raw, ev_set;
  logic [EV_COUNT-1:0] masked_status;

  // -----------------------------------------------------------------
  // write channel
  // -----------------------------------------------------------------
  logic aw_held_ff, w_held_ff, bvalid_ff;
  logic [ADDR_W-1:0] aw_addr_ff;
  logic [31:0] w_data_ff;
  logic [3:0] w_strb_ff;
  logic do_write;
  logic [1:0] bresp_ff;

  // only one write in flight: new halves wait until the response is taken
  assign s_axi_awready = !aw_held_ff && !bvalid_ff;
  assign s_axi_wready = !w_held_ff && !bvalid_ff;
  assign do_write = aw_held_ff && w_held_ff && !bvalid_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      aw_held_ff <= 1'b0;
      aw_addr_ff <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_ff <= 1'b1;
      aw_addr_ff <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held_ff <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      w_held_ff <= 1'b0;
      w_data_ff <= 32'h0000_0000;
      w_strb_ff <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_ff <= 1'b1;
      w_data_ff <= s_axi_wdata;
      w_strb_ff <= s_axi_wstrb;
    end else if (do_write) begin
      w_held_ff <= 1'b0;
    end
  end

  function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
    logic hit;
    hit = 1'b0;
    unique case (a)
      ADDR_HS_HIGH, ADDR_HS_LOW, ADDR_MASKED_STATUS, ADDR_EVENT_MASK,
      ADDR_RAW_STATUS, ADDR_RX_THRESHOLD, ADDR_TX_THRESHOLD,
      ADDR_COMBINED_CLEAR: hit = 1'b1;
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction : addr_mapped

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
    end else if (do_write) begin
      bvalid_ff <= 1'b1;
      // writes to read-only views are dropped but still answered okay
      bresp_ff <= addr_mapped(aw_addr_ff) ? RESP_OKAY : RESP_DECERR;
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  // -----------------------------------------------------------------
  // software-written registers, byte lanes honoured
  // -----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      hs_high_ff <= HS_COUNT_RESET;
      hs_low_ff <= HS_COUNT_RESET;
    end else if (do_write) begin
      if (aw_addr_ff == ADDR_HS_HIGH) begin
        if (w_strb_ff[0]) hs_high_ff[7:0] <= w_data_ff[7:0];
        if (w_strb_ff[1]) hs_high_ff[15:8] <= w_data_ff[15:8];
      end
      if (aw_addr_ff == ADDR_HS_LOW) begin
        if (w_strb_ff[0]) hs_low_ff[7:0] <= w_data_ff[7:0];
        if (w_strb_ff[1]) hs_low_ff[15:8] <= w_data_ff[15:8];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      mask_ff <= EVENT_MASK_RESET;
    end else if (do_write && aw_addr_ff == ADDR_EVENT_MASK) begin
      if (w_strb_ff[0]) mask_ff[7:0] <= w_data_ff[7:0];
      if (w_strb_ff[1]) mask_ff[11:8] <= w_data_ff[11:8];
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      receive_threshold_level_ff <= THRESHOLD_RESET;
      transmit_threshold_level_ff <= THRESHOLD_RESET;
    end else if (do_write && w_strb_ff[0]) begin
      if (aw_addr_ff == ADDR_RX_THRESHOLD) receive_threshold_level_ff <= w_data_ff[7:0];
      if (aw_addr_ff == ADDR_TX_THRESHOLD) transmit_threshold_level_ff <= w_data_ff[7:0];
    end
  end

  // hs counts feed the scl generator directly
  assign hs_scl_high_count = hs_high_ff;
  assign hs_scl_low_count = hs_low_ff;
  assign receive_threshold_level = receive_threshold_level_ff;
  assign transmit_threshold_level = transmit_threshold_level_ff;

  // -----------------------------------------------------------------
  // read channel
  // -----------------------------------------------------------------
  logic rvalid_ff, combined_clear;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;

  assign s_axi_arready = !rvalid_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  assign combined_clear = s_axi_arvalid && s_axi_arready &&
                          s_axi_araddr == ADDR_COMBINED_CLEAR;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_ff <= 1'b1;
      rresp_ff <= addr_mapped(s_axi_araddr) ? RESP_OKAY : RESP_DECERR;
      unique case (s_axi_araddr)
        ADDR_HS_HIGH: rdata_ff <= {16'h0000, hs_high_ff};
        ADDR_HS_LOW: rdata_ff <= {16'h0000, hs_low_ff};
        ADDR_MASKED_STATUS: rdata_ff <= {20'h0_0000, masked_status};
        ADDR_EVENT_MASK: rdata_ff <= {20'h0_0000, mask_ff};
        ADDR_RAW_STATUS: rdata_ff <= {20'h0_0000, raw_ff};
        ADDR_RX_THRESHOLD: rdata_ff <= {24'h00_0000, receive_threshold_level_ff};
        ADDR_TX_THRESHOLD: rdata_ff <= {24'h00_0000, transmit_threshold_level_ff};
        // returns the combined interrupt as it stood before the clear
        ADDR_COMBINED_CLEAR: rdata_ff <= {31'h0000_0000, intr};
        default: rdata_ff <= 32'h0000_0000;
      endcase
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  // -----------------------------------------------------------------
  // event capture
  // -----------------------------------------------------------------
  always_comb begin
    ev_set = '0;
    ev_set[EV_GENERAL_CALL] = general_call_ack_pulse;
    ev_set[EV_START_SEEN] = cond.start_pulse;
    ev_set[EV_STOP_SEEN] = cond.stop_pulse;
    ev_set[EV_ACTIVITY] = activity_pulse;
    ev_set[EV_SLAVE_TX_DONE] = slave_tx_nack_pulse;
    ev_set[EV_TX_ABORT] = tx_abort_pulse;
    ev_set[EV_READ_REQUEST] = read_request_pulse;
    ev_set[EV_TX_OVERFLOW] = data_cmd_write_pulse && tx_fifo_level >= TX_FULL_LEVEL;
    ev_set[EV_RX_OVERFLOW] = rx_byte_pulse && rx_fifo_level >= RX_FULL_LEVEL;
    ev_set[EV_RX_UNDERFLOW] = data_cmd_read_pulse && rx_fifo_level == '0;
    // a new event in the clearing cycle survives the clear
    nxt_raw = (raw_ff & ~({EV_COUNT{combined_clear}} & STICKY_EVENTS)) | ev_set;
    nxt_raw[EV_TX_EMPTY] = {{(32-LEVEL_W){1'b0}}, tx_fifo_level} <=
                           {{(32-THRESHOLD_W){1'b0}}, transmit_threshold_level_ff};
    nxt_raw[EV_RX_FULL] = {{(32-LEVEL_W){1'b0}}, rx_fifo_level} >=
                          {{(32-THRESHOLD_W){1'b0}}, receive_threshold_level_ff};
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      raw_ff <= EVENT_RESET;
    end else begin
      raw_ff <= nxt_raw;
    end
  end

  assign masked_status = raw_ff & mask_ff;
  assign intr = |masked_status;

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  a_general_call_flag_set: assert property (general_call_ack_pulse |=> raw_ff[EV_GENERAL_CALL])
    else $error("general call flag not set");
  a_general_call_flag_cause: assert property ($rose(raw_ff[EV_GENERAL_CALL]) |->
    $past(general_call_ack_pulse))
    else $error("general call flag set without acked call");
  a_start_set: assert property (cond.start_pulse |=> raw_ff[EV_START_SEEN])
    else $error("start flag not set");
  a_stop_set: assert property (cond.stop_pulse |=> raw_ff[EV_STOP_SEEN])
    else $error("stop flag not set");
  a_activity_sticks: assert property (raw_ff[EV_ACTIVITY] && !combined_clear
    |=> raw_ff[EV_ACTIVITY])
    else $error("activity flag dropped without clear");
  a_nack_set: assert property (slave_tx_nack_pulse |=> raw_ff[EV_SLAVE_TX_DONE])
    else $error("slave transmit nack flag not set");
  a_abort_set: assert property (tx_abort_pulse |=> raw_ff[EV_TX_ABORT])
    else $error("abort flag not set");
  a_read_req_set: assert property (read_request_pulse |=> raw_ff[EV_READ_REQUEST])
    else $error("read request flag not set");
  // raw still holds its reset value at the first edge after release
  a_tx_empty_level: assert property ($past(resetn) |-> raw_ff[EV_TX_EMPTY] ==
    ($past(tx_fifo_level) <= $past(transmit_threshold_level_ff)))
    else $error("transmit empty disagrees with threshold");
  a_tx_over_set: assert property (data_cmd_write_pulse && tx_fifo_level == TX_FULL_LEVEL
    |=> raw_ff[EV_TX_OVERFLOW])
    else $error("transmit overflow not set");
  a_rx_full_level: assert property ($past(resetn) |-> raw_ff[EV_RX_FULL] ==
    ($past(rx_fifo_level) >= $past(receive_threshold_level_ff)))
    else $error("receive full disagrees with threshold");
  a_rx_over_set: assert property (rx_byte_pulse && rx_fifo_level == RX_FULL_LEVEL
    |=> raw_ff[EV_RX_OVERFLOW])
    else $error("receive overflow not set");
  a_rx_under_set: assert property (data_cmd_read_pulse && rx_fifo_level == '0
    |=> raw_ff[EV_RX_UNDERFLOW])
    else $error("receive underflow not set");
  a_mask_after_reset: assert property ($rose(resetn) |-> mask_ff == 12'h8ff)
    else $error("mask reset value wrong");
  a_clear_sticky: assert property (combined_clear && ev_set == '0
    |=> (raw_ff & STICKY_EVENTS) == '0)
    else $error("combined clear left a sticky flag");
  a_intr_follows: assert property (raw_ff[EV_GENERAL_CALL] && mask_ff[EV_GENERAL_CALL]
    |-> intr ##0 masked_status[EV_GENERAL_CALL])
    else $error("interrupt low with a masked event");
  a_mask_blocks: assert property (mask_ff == '0 |-> !intr)
    else $error("zero mask let an event through");
  a_hs_high_load: assert property (do_write && aw_addr_ff == ADDR_HS_HIGH && w_strb_ff[1:0] == 2'h3
    |=> hs_scl_high_count == $past(w_data_ff[15:0]))
    else $error("high count not loaded");
  a_hs_low_load: assert property (do_write && aw_addr_ff == ADDR_HS_LOW && w_strb_ff[1:0] == 2'h3
    |=> hs_scl_low_count == $past(w_data_ff[15:0]))
    else $error("low count not loaded");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered next cycle");
endmodule : ihs_event_regs
`default_nettype wire

// File: test/ihs_bus_model.sv
`timescale 1ns/1ps
`default_nettype none
module ihs_bus_model (
  output logic scl,
  output logic sda
);
  // ---------------------------------------------------------------
  // pulled-up lines rest high; scl stands still between frames
  // ---------------------------------------------------------------
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end

  // start, two scl cycles of 125 ns, then stop
  task automatic frame();
    // step off the system clock edge before touching the pins
    #1.25;
    sda = 1'b0;
    #62.5 scl = 1'b0;
    #62.5 scl = 1'b1;
    #62.5 scl = 1'b0;
    #62.5 scl = 1'b1;
    #62.5 sda = 1'b1;
    #62.5;
  endtask : frame
endmodule : ihs_bus_model
`default_nettype wire

// File: test/ihs_event_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module ihs_event_regs_tb;
  import ihs_pkg::*;
  logic sys_clk, resetn, scl, sda, intr;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0] pl, tl, rl, tx_thr, rx_thr;
  logic [15:0] hi_o, lo_o;
  logic [7:0] rth_o, tth_o;
  logic [11:0] msk;
  logic [33:0] rd_q[$];
  logic [1:0] wr_q[$];
  logic [31:0] dv[4];
  int bad_count, checks, cyc;
  logic [6:0] ra[4] = '{ADDR_HS_HIGH, ADDR_HS_LOW, ADDR_RX_THRESHOLD, ADDR_TX_THRESHOLD};
  logic [31:0] rm[4] = '{32'h0000_ffff, 32'h0000_ffff, 32'h0000_00ff, 32'h0000_00ff};
  logic [7:0] c_p[11] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h08, 8'h04, 8'h04, 8'h01, 8'h01,
    8'h02, 8'h02};
  logic [7:0] c_tl[11] = '{8'h06, 8'h06, 8'h06, 8'h06, 8'h06, 8'h08, 8'h07, 8'h06, 8'h06,
    8'h06, 8'h06};
  logic [7:0] c_rl[11] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h08, 8'h07,
    8'h00, 8'h01};
  logic [11:0] c_e[11] = '{12'h800, 12'h100, 12'h080, 12'h040, 12'h020, 12'h008, 12'h000,
    12'h002, 12'h000, 12'h001, 12'h000};

  ihs_event_regs u_dut (
    .sys_clk(sys_clk), .resetn(resetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(1'b1), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(1'b1), .scl_in(scl), .sda_in(sda),
    .general_call_ack_pulse(pl[7]), .activity_pulse(pl[6]), .slave_tx_nack_pulse(pl[5]),
    .tx_abort_pulse(pl[4]), .read_request_pulse(pl[3]), .data_cmd_write_pulse(pl[2]),
    .data_cmd_read_pulse(pl[1]), .rx_byte_pulse(pl[0]), .tx_fifo_level(tl),
    .rx_fifo_level(rl), .hs_scl_high_count(hi_o), .hs_scl_low_count(lo_o),
    .receive_threshold_level(rth_o), .transmit_threshold_level(tth_o), .intr(intr));
  ihs_bus_model u_bus (.scl(scl), .sda(sda));

  always #2.5 sys_clk = ~sys_clk;

  // -----------------------------------------------------------------
  // checking and closing
  // -----------------------------------------------------------------
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : test_done

  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  // ready lines are held high, so every valid edge is a handshake
  always @(posedge sys_clk) begin
    if (s_axi_rvalid === 1'b1) begin
      check({s_axi_rresp, s_axi_rdata}, rd_q.size() ? rd_q.pop_front() : 34'h3_ffff_ffff);
    end
    if (s_axi_bvalid === 1'b1) begin
      check(s_axi_bresp, wr_q.size() ? wr_q.pop_front() : 2'h1);
    end
  end

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      test_done();
    end
  end

  // -----------------------------------------------------------------
  // bus master and stimulus helpers
  // -----------------------------------------------------------------
  task automatic wr(input logic [6:0] a, input logic [31:0] d, input logic [1:0] r);
    wr_q.push_back(r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
  endtask : wr

  task automatic rd(input logic [6:0] a, input logic [33:0] e);
    rd_q.push_back(e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
  endtask : rd

  // level-driven bits as this bench expects them from its own levels
  function automatic logic [11:0] lv();
    lv = 12'h000;
    lv[EV_TX_EMPTY] = (tl <= tx_thr);
    lv[EV_RX_FULL] = (rl >= rx_thr);
  endfunction : lv

  task automatic pulse(input logic [7:0] p);
    pl <= p;
    @(posedge sys_clk);
    pl <= 8'h00;
    repeat (2) @(posedge sys_clk);
  endtask : pulse

  // -----------------------------------------------------------------
  // main sequence
  // -----------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    resetn = 1'b0;
    s_axi_awaddr = 7'h00;
    s_axi_araddr = 7'h00;
    s_axi_wdata = 32'h0000_0000;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_arvalid = 1'b0;
    pl = 8'h00;
    tl = 8'h03;
    rl = 8'h00;
    tx_thr = 8'h00;
    rx_thr = 8'h00;
    msk = 12'h8ff;
    void'($urandom(32'h2d20f60f));
    repeat (3) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    rd(ADDR_EVENT_MASK, {RESP_OKAY, 32'h0000_08ff});
    for (int i = 0; i < 4; i++) rd(ra[i], {RESP_OKAY, 32'h0000_0000});
    rd(ADDR_RAW_STATUS, {RESP_OKAY, 20'h0_0000, lv()});
    rd(ADDR_MASKED_STATUS, {RESP_OKAY, 20'h0_0000, lv() & msk});
    for (int i = 0; i < 4; i++) begin
      dv[i] = $urandom();
      wr(ra[i], dv[i], RESP_OKAY);
      rd(ra[i], {RESP_OKAY, dv[i] & rm[i]});
    end
    check({hi_o, lo_o}, {dv[0][15:0], dv[1][15:0]});
    wr(ADDR_TX_THRESHOLD, 32'h0000_0005, RESP_OKAY);
    wr(ADDR_RX_THRESHOLD, 32'h0000_0004, RESP_OKAY);
    tx_thr = 8'h05;
    rx_thr = 8'h04;
    check({rth_o, tth_o}, 16'h0405);
    wr(ADDR_EVENT_MASK, 32'h0000_0fff, RESP_OKAY);
    msk = 12'hfff;
    rd(ADDR_EVENT_MASK, {RESP_OKAY, 32'h0000_0fff});
    wr(ADDR_RAW_STATUS, 32'hffff_ffff, RESP_OKAY);
    wr(7'h44, 32'hffff_ffff, RESP_DECERR);
    rd(7'h44, {RESP_DECERR, 32'h0000_0000});
    for (int i = 0; i < 11; i++) begin
      tl <= c_tl[i];
      rl <= c_rl[i];
      @(posedge sys_clk);
      pulse(c_p[i]);
      rd(ADDR_RAW_STATUS, {RESP_OKAY, 20'h0_0000, c_e[i] | lv()});
      rd(ADDR_COMBINED_CLEAR, {RESP_OKAY, 31'h0, |((c_e[i] | lv()) & msk)});
      rd(ADDR_RAW_STATUS, {RESP_OKAY, 20'h0_0000, lv()});
    end
    u_bus.frame();
    repeat (4) @(posedge sys_clk);
    rd(ADDR_RAW_STATUS, {RESP_OKAY, 20'h0_0000, 12'h600 | lv()});
    wr(ADDR_EVENT_MASK, 32'h0000_0000, RESP_OKAY);
    msk = 12'h000;
    rd(ADDR_MASKED_STATUS, {RESP_OKAY, 32'h0000_0000});
    check(intr, 1'b0);
    wr(ADDR_EVENT_MASK, 32'h0000_0600, RESP_OKAY);
    msk = 12'h600;
    rd(ADDR_MASKED_STATUS, {RESP_OKAY, 32'h0000_0600});
    check(intr, 1'b1);
    rd(ADDR_COMBINED_CLEAR, {RESP_OKAY, 32'h0000_0001});
    rd(ADDR_RAW_STATUS, {RESP_OKAY, 20'h0_0000, lv()});
    repeat (2) @(posedge sys_clk);
    check(rd_q.size() + wr_q.size(), 34'h0);
    test_done();
  end
endmodule : ihs_event_regs_tb
`default_nettype wire
